// >>> rtl/bbrc_pkg.sv
// constants and types of the backlight brightness ramp controller
package bbrc_pkg;
  // clock rate and microsecond scale
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_US = CLK_HZ / 1_000_000;
  // apb byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_BOOST = 8'h04;
  localparam logic [7:0] OFS_BRA   = 8'h08;
  localparam logic [7:0] OFS_BRB   = 8'h0c;
  localparam logic [7:0] OFS_FSA   = 8'h10;
  localparam logic [7:0] OFS_FSB   = 8'h14;
  localparam logic [7:0] OFS_ONOFF = 8'h18;
  localparam logic [7:0] OFS_RUN   = 8'h1c;
  localparam logic [7:0] OFS_FAULT = 8'h20;
  localparam logic [7:0] OFS_SWRST = 8'h24;
  localparam logic [7:0] OFS_STAT  = 8'h28;
  // reset values
  localparam logic [5:0] RST_CFG   = 6'h30;
  localparam logic [3:0] RST_BOOST = 4'h4;
  localparam logic [4:0] RST_FS    = 5'h1f;
  // configuration fields
  localparam int CFG_LIN   = 0;
  localparam int CFG_BANKB = 1;
  localparam int CFG_DIMLO = 2;
  localparam int CFG_DIMEN = 3;
  localparam int CFG_FB    = 4;
  // boost control fields
  localparam int BST_FHI   = 0;
  localparam int BST_SHIFT = 1;
  localparam int BST_OVP   = 2;
  // fault register fields
  localparam int FLT_MEN   = 0;
  localparam int FLT_OPEN  = 2;
  localparam int FLT_SHORT = 4;
  // ramp code fields: startup/up low, shutdown/down high
  localparam int RMP_LO    = 0;
  localparam int RMP_HI    = 3;
  // full-scale current in microamps
  localparam logic [14:0] FS_BASE_UA  = 15'h1388;
  localparam logic [9:0]  FS_STEP_UA  = 10'h2ee;
  // exponential slope, octaves per code step in 1/1024
  localparam logic [5:0]  EXP_OCT_Q10 = 6'h29;
  // ramp times in microseconds and their cycle counts
  localparam int unsigned START_MIN_US  = 4000;
  localparam int unsigned SHUT_ZERO_US  = 500;
  localparam int unsigned RAMP_BASE_US  = 261_000;
  localparam int unsigned START_MIN_CYC = START_MIN_US * CYC_US;
  localparam int unsigned SHUT_ZERO_CYC = SHUT_ZERO_US * CYC_US;
  localparam int unsigned RAMP_BASE_CYC = RAMP_BASE_US * CYC_US;
  // boost switching frequencies and half periods in cycles
  localparam int unsigned F_LO_KHZ  = 500;
  localparam int unsigned F_HI_KHZ  = 1000;
  localparam int unsigned F_LOS_KHZ = 560;
  localparam int unsigned F_HIS_KHZ = 1120;
  localparam logic [6:0] HALF_LO  = 7'(CLK_HZ / (2 * F_LO_KHZ * 1000));
  localparam logic [6:0] HALF_HI  = 7'(CLK_HZ / (2 * F_HI_KHZ * 1000));
  localparam logic [6:0] HALF_LOS = 7'(CLK_HZ / (2 * F_LOS_KHZ * 1000));
  localparam logic [6:0] HALF_HIS = 7'(CLK_HZ / (2 * F_HIS_KHZ * 1000));
  // analog comparator results, one bit per sink where paired
  typedef struct packed {
    logic       ovp_hit;
    logic [1:0] below_open;
    logic [1:0] near_ovp;
    logic [1:0] near_vin;
    logic       s2_higher;
  } bbrc_sense_s;
  // ramp engine states
  typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_RAMP = 2'b01} bbrc_rstate_e;
endpackage

// >>> rtl/bbrc_ramp.sv
// brightness ramp engine of one control bank
`timescale 1ns/1ps
module bbrc_ramp (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clr,
  input  wire logic        go,
  input  wire logic [7:0]  tgt,
  input  wire logic [31:0] dur,
  output logic      [7:0]  level_q
);
  import bbrc_pkg::*;

  bbrc_rstate_e st_q;
  logic [7:0]   goal_q;
  logic [7:0]   dist_q;
  logic [31:0]  len_q;
  logic [31:0]  acc_q;
  logic [32:0]  sum;
  logic [7:0]   dist_d;

  // accumulate distance per cycle, one code step per wrap of the length
  assign sum    = {1'b0, acc_q} + {25'h0, dist_q};
  assign dist_d = (tgt > level_q) ? tgt - level_q : level_q - tgt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= RS_IDLE;
      goal_q  <= 8'h00;
      dist_q  <= 8'h00;
      len_q   <= 32'h0;
      acc_q   <= 32'h0;
      level_q <= 8'h00;
    end else if (clr) begin
      st_q    <= RS_IDLE;
      acc_q   <= 32'h0;
      level_q <= 8'h00;
    end else if (go) begin
      goal_q <= tgt;
      dist_q <= dist_d;
      len_q  <= dur;
      acc_q  <= 32'h0;
      if (dur == 32'h0) begin
        level_q <= tgt;
        st_q    <= RS_IDLE;
      end else begin
        st_q <= RS_RAMP;
      end
    end else if (st_q == RS_RAMP) begin
      if (level_q == goal_q) begin
        st_q <= RS_IDLE;
      end else if (sum >= {1'b0, len_q}) begin
        acc_q   <= 32'(sum - {1'b0, len_q});
        level_q <= (goal_q > level_q) ? level_q + 8'h01 : level_q - 8'h01;
      end else begin
        acc_q <= sum[31:0];
      end
    end
  end
endmodule

// >>> rtl/bbrc_map.sv
// brightness code to current set-point mapping of one bank
`timescale 1ns/1ps
module bbrc_map (
  input  wire logic [7:0]  code,
  input  wire logic [4:0]  fs,
  input  wire logic        lin,
  output logic      [14:0] ua
);
  import bbrc_pkg::*;

  // 2 to the minus i/16 in 1/4096
  localparam logic [15:0][11:0] POW2 = {
    12'h85a, 12'h8b9, 12'h91c, 12'h983, 12'h9ef, 12'ha60, 12'had6,
    12'hb50, 12'hbd1, 12'hc56, 12'hce2, 12'hd74, 12'he0d, 12'heac,
    12'hf52, 12'hfff};
  logic [14:0] fs_ua;
  logic [13:0] oct;
  logic [26:0] prod;
  logic [22:0] lin_p;
  logic [14:0] exp_ua;
  logic [14:0] lin_ua;

  assign fs_ua = FS_BASE_UA + {10'h0, fs} * {5'h0, FS_STEP_UA};
  // exponential law, octaves below full scale
  assign oct    = {6'h0, 8'hff - code} * {8'h0, EXP_OCT_Q10};
  assign prod   = {12'h0, fs_ua} * {15'h0, POW2[oct[9:6]]};
  assign exp_ua = 15'((prod >> 12) >> oct[13:10]);
  assign lin_p  = {8'h0, fs_ua} * {15'h0, code};
  assign lin_ua = 15'(lin_p / 23'h0000ff);
  // code 255 gives exact full scale, code 0 gives off
  // the table tops out just under one, so the top code bypasses it
  assign ua = (code == 8'h00) ? 15'h0 :
              (code == 8'hff) ? fs_ua : (lin ? lin_ua : exp_ua);
endmodule

// >>> rtl/bbrc_top.sv
// backlight brightness ramp controller with apb registers
//
// Behaviour
// - boost runs at 500 kHz or 1 MHz
// - offset bit moves to 560/1120 kHz
// - two strings: higher-voltage string steers headroom
// - each sink feedback can be disabled
// - full scale is 5 mA plus 0.75 mA steps
// - code 255 gives exactly full scale
// - each bank has its own brightness code
// - exponential mapping scaled by dimming duty
// - linear mapping scaled by dimming duty
// - shared 3-bit startup and shutdown codes
// - startup from zero, shutdown to zero
// - enable pin low cuts current at once
// - zero shutdown code takes half a millisecond
// - shared 3-bit run ramp up/down codes
// - run ramps between nonzero brightness values
// - test faults never reach interrupt pin
// - open string: low sink at ovp
// - short: sink within 1V of rail
// - fault register bit 0 enables test ovp
// - test ovp stops boost and flags
// - only reset restarts boost after test ovp
// - enable pin low restores all defaults
// - second sink on bank A or B
// - selectable dimming input polarity
`timescale 1ns/1ps
module bbrc_top #(
  parameter int unsigned START_MIN_CYC_P = bbrc_pkg::START_MIN_CYC,
  parameter int unsigned SHUT_ZERO_CYC_P = bbrc_pkg::SHUT_ZERO_CYC,
  parameter int unsigned RAMP_BASE_CYC_P = bbrc_pkg::RAMP_BASE_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  hardware_enable_pin,
  input  wire logic                  dim_in,
  input  wire bbrc_pkg::bbrc_sense_s sense,
  output logic      [1:0][14:0]      string_current,
  output logic      [1:0]            sink_on,
  output logic      [1:0]            headroom_minimum_selector,
  output logic      [1:0]            overvoltage_threshold,
  output logic                       boost_run,
  output logic                       boost_switch
);
  import bbrc_pkg::*;

  // refuse counts that the ramp cannot hold; one step a cycle needs 255
  if (RAMP_BASE_CYC_P < 255 || RAMP_BASE_CYC_P >= 2**25 ||
      START_MIN_CYC_P < 255 || SHUT_ZERO_CYC_P < 255) begin : g_chk
    $error("ramp cycle counts out of range");
  end

  logic [5:0]       cfg_q;
  logic [3:0]       bst_q;
  logic [1:0][7:0]  bri_q;
  logic [1:0][4:0]  fs_q;
  logic [5:0]       onoff_q;
  logic [5:0]       run_q;
  logic             men_q;
  logic             ovpf_q;
  logic [1:0]       open_q;
  logic [1:0]       short_q;
  logic             soft_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [1:0][14:0] cur_q;
  logic [1:0][14:0] cur_d;
  logic [1:0]       on_q;
  logic [1:0]       hsel_q;
  logic             boost_q;
  logic             sw_q;
  logic [6:0]       div_q;
  logic [6:0]       half;
  logic             clr;
  logic             setup;
  logic             wr;
  logic             dim_act;
  logic [1:0]       fb;
  logic [1:0]       go;
  logic [1:0][31:0] dur;
  logic [1:0][7:0]  lvl;
  logic [1:0][14:0] bank_ua;

  // write strobe for one register offset
  function automatic logic hit(input logic [7:0] ofs);
    hit = wr && (paddr == ofs);
  endfunction

  // ramp length in cycles for a 3-bit code and its zero-code length
  function automatic logic [31:0] ramp_len(input logic [2:0]  c,
                                           input logic [31:0] z);
    if (c == 3'h0) begin
      ramp_len = z;
    end else begin
      ramp_len = RAMP_BASE_CYC_P[31:0] << (c - 3'h1);
    end
  endfunction

  // apb phases and the clear from pin or software
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready_q && pwrite;
  // pin low holds every register at default
  assign clr   = !hardware_enable_pin || soft_q;
  assign fb    = cfg_q[CFG_FB +: 2];

  // outputs straight from their flops
  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign string_current            = cur_q;
  assign sink_on                   = on_q;
  assign headroom_minimum_selector = hsel_q;
  assign overvoltage_threshold     = bst_q[BST_OVP +: 2];
  assign boost_run                 = boost_q;
  assign boost_switch              = sw_q;

  // apb ready in access phase, read data latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= 1'b0;
      if (setup) begin
        if (paddr == OFS_CFG) begin
          prdata_q <= {26'h0, cfg_q};
        end else if (paddr == OFS_BOOST) begin
          prdata_q <= {28'h0, bst_q};
        end else if (paddr == OFS_BRA) begin
          prdata_q <= {24'h0, bri_q[0]};
        end else if (paddr == OFS_BRB) begin
          prdata_q <= {24'h0, bri_q[1]};
        end else if (paddr == OFS_FSA) begin
          prdata_q <= {27'h0, fs_q[0]};
        end else if (paddr == OFS_FSB) begin
          prdata_q <= {27'h0, fs_q[1]};
        end else if (paddr == OFS_ONOFF) begin
          prdata_q <= {26'h0, onoff_q};
        end else if (paddr == OFS_RUN) begin
          prdata_q <= {26'h0, run_q};
        end else if (paddr == OFS_FAULT) begin
          prdata_q <= {26'h0, short_q, open_q, ovpf_q, men_q};
        end else if (paddr == OFS_SWRST) begin
          prdata_q <= 32'h0;
        end else if (paddr == OFS_STAT) begin
          prdata_q <= {1'b0, cur_q[1], boost_q, cur_q[0]};
        end else begin
          prdata_q  <= 32'h0;
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // software reset pulse, clears registers on the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= hit(OFS_SWRST) && pwdata[0];
    end
  end

  // configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= RST_CFG;
      bst_q   <= RST_BOOST;
      fs_q    <= {RST_FS, RST_FS};
      onoff_q <= 6'h00;
      run_q   <= 6'h00;
      men_q   <= 1'b0;
    end else if (clr) begin
      cfg_q   <= RST_CFG;
      bst_q   <= RST_BOOST;
      fs_q    <= {RST_FS, RST_FS};
      onoff_q <= 6'h00;
      run_q   <= 6'h00;
      men_q   <= 1'b0;
    end else begin
      if (hit(OFS_CFG)) begin
        cfg_q <= pwdata[5:0];
      end
      if (hit(OFS_BOOST)) begin
        bst_q <= pwdata[3:0];
      end
      if (hit(OFS_FSA)) begin
        fs_q[0] <= pwdata[4:0];
      end
      if (hit(OFS_FSB)) begin
        fs_q[1] <= pwdata[4:0];
      end
      if (hit(OFS_ONOFF)) begin
        onoff_q <= pwdata[5:0];
      end
      if (hit(OFS_RUN)) begin
        run_q <= pwdata[5:0];
      end
      if (hit(OFS_FAULT)) begin
        men_q <= pwdata[FLT_MEN];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bri_q <= 16'h0000;
    end else if (clr) begin
      bri_q <= 16'h0000;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (go[b]) begin
          bri_q[b] <= pwdata[7:0];
        end
      end
    end
  end

  // a brightness write picks the ramp length for its bank
  always_comb begin
    logic [7:0] nb;
    nb = pwdata[7:0];
    for (int b = 0; b < 2; b++) begin
      go[b] = hit((b == 0) ? OFS_BRA : OFS_BRB);
      if (nb == 8'h00) begin
        // zero code still takes half a ms
        dur[b] = ramp_len(onoff_q[RMP_HI +: 3], SHUT_ZERO_CYC_P[31:0]);
      end else if (bri_q[b] == 8'h00) begin
        dur[b] = ramp_len(onoff_q[RMP_LO +: 3], START_MIN_CYC_P[31:0]);
      end else if (nb > bri_q[b]) begin
        dur[b] = ramp_len(run_q[RMP_LO +: 3], 32'h0);
      end else begin
        dur[b] = ramp_len(run_q[RMP_HI +: 3], 32'h0);
      end
    end
  end

  // ramp engine and current mapping for each bank
  for (genvar g = 0; g < 2; g++) begin : g_bank
    bbrc_ramp u_ramp (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (clr),
      .go      (go[g]),
      .tgt     (pwdata[7:0]),
      .dur     (dur[g]),
      .level_q (lvl[g])
    );
    bbrc_map u_map (
      .code (lvl[g]),
      .fs   (fs_q[g]),
      .lin  (cfg_q[CFG_LIN]),
      .ua   (bank_ua[g])
    );
  end

  // sink set-points from their banks
  always_comb begin
    cur_d[0] = bank_ua[0];
    cur_d[1] = cfg_q[CFG_BANKB] ? bank_ua[1] : bank_ua[0];
  end

  assign dim_act = !cfg_q[CFG_DIMEN] || (dim_in ^ cfg_q[CFG_DIMLO]);

  // current set-points and sink gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 30'h0;
      on_q  <= 2'b00;
    end else if (clr) begin
      cur_q <= 30'h0;
      on_q  <= 2'b00;
    end else begin
      cur_q <= cur_d;
      for (int i = 0; i < 2; i++) begin
        on_q[i] <= (cur_d[i] != 15'h0) && dim_act;
      end
    end
  end

  // headroom loop string selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsel_q <= 2'b00;
    end else if (clr) begin
      hsel_q <= 2'b00;
    end else if (&fb) begin
      hsel_q <= sense.s2_higher ? 2'b10 : 2'b01;
    end else begin
      hsel_q <= fb;
    end
  end

  // shift bit picks offset half period
  always_comb begin
    case ({bst_q[BST_FHI], bst_q[BST_SHIFT]})
      2'b00:   half = HALF_LO;
      2'b01:   half = HALF_LOS;
      2'b10:   half = HALF_HI;
      default: half = HALF_HIS;
    endcase
  end

  // boost allowed while enabled, unfaulted and driving current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_q <= 1'b0;
    end else begin
      boost_q <= !clr && !ovpf_q && (cur_d != 30'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
      sw_q  <= 1'b0;
    end else if (!boost_q) begin
      div_q <= 7'h00;
      sw_q  <= 1'b0;
    end else if (div_q >= half - 7'h01) begin
      div_q <= 7'h00;
      sw_q  <= !sw_q;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // test ovp latch, cleared only by pin or software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovpf_q <= 1'b0;
    end else if (clr) begin
      ovpf_q <= 1'b0;
    end else if (men_q && sense.ovp_hit) begin
      ovpf_q <= 1'b1;
    end
  end

  // open and short test flags, write one to clear, set wins;
  // these flags feed no interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q  <= 2'b00;
      short_q <= 2'b00;
    end else if (clr) begin
      open_q  <= 2'b00;
      short_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        open_q[i] <= (fb[i] && sense.below_open[i] && sense.ovp_hit) ||
                     (open_q[i] &&
                      !(hit(OFS_FAULT) && pwdata[FLT_OPEN + i]));
        short_q[i] <= (fb[i] ? sense.near_ovp[i] : sense.near_vin[i]) ||
                      (short_q[i] &&
                       !(hit(OFS_FAULT) && pwdata[FLT_SHORT + i]));
      end
    end
  end
endmodule

// >>> testbench/bbrc_top_checker.sv
// port assertions for the ramp controller top
`timescale 1ns/1ps
module bbrc_top_checker (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             hardware_enable_pin,
  input wire logic [1:0][14:0] string_current,
  input wire logic [1:0]       headroom_minimum_selector,
  input wire logic [1:0]       overvoltage_threshold,
  input wire logic             boost_run,
  input wire logic             boost_switch
);
  import bbrc_pkg::*;
  logic [7:0] hcnt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last switching edge, restarted while boost is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 8'h00;
    end else if (!boost_run || boost_switch != $past(boost_switch)) begin
      hcnt_q <= 8'h01;
    end else if (hcnt_q != 8'hff) begin
      hcnt_q <= hcnt_q + 8'h01;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pin_low2;
    !hardware_enable_pin [*2];
  endsequence
  chk_ready_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_cause: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_pin_cut: assert property (
    !hardware_enable_pin |=> string_current == '0)
    else $error("current not cut by enable pin");
  chk_pin_boost: assert property (
    s_pin_low2 |=> !boost_run)
    else $error("boost runs with enable pin low");
  chk_pin_default: assert property (
    !hardware_enable_pin |=> overvoltage_threshold == 2'b01)
    else $error("threshold not back to default");
  chk_sel_onehot: assert property (
    $onehot0(headroom_minimum_selector))
    else $error("two strings steer headroom");
  chk_cur_max: assert property (
    string_current[0] <= 15'h6e5a && string_current[1] <= 15'h6e5a)
    else $error("current above full scale");
  chk_sw_idle: assert property (
    !boost_run [*2] |-> !boost_switch)
    else $error("switching while boost stopped");
  chk_half_max: assert property (
    boost_run && $changed(boost_switch) |-> hcnt_q <= 8'h33)
    else $error("switching half period too long");
endmodule
bind bbrc_top bbrc_top_checker bbrc_top_checker_i (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .hardware_enable_pin, .string_current, .headroom_minimum_selector,
  .overvoltage_threshold, .boost_run, .boost_switch
);

// >>> testbench/bbrc_afe_model.sv
// behavioural analog front end and dimming source
`timescale 1ns/1ps
module bbrc_afe_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            boost_run,
  input  wire logic [4:0]      duty,
  input  wire logic [1:0]      open_str,
  input  wire logic [1:0]      short_ovp,
  input  wire logic [1:0]      short_vin,
  input  wire logic            s2_high,
  output logic                 dim_in,
  output bbrc_pkg::bbrc_sense_s sense
);
  import bbrc_pkg::*;
  logic [3:0] ph_q;
  // dimming phase, sixteen cycles a period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end
  // dimming input high for duty sixteenths of a period
  assign dim_in = {1'b0, ph_q} < duty;
  assign sense.ovp_hit = boost_run & |open_str;
  assign sense.below_open = open_str;
  assign sense.near_ovp = short_ovp;
  assign sense.near_vin = short_vin;
  assign sense.s2_higher = s2_high;
endmodule

// >>> testbench/tb.sv
// self-checking bench of the ramp controller
`timescale 1ns/1ps
module tb;
  import bbrc_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             hardware_enable_pin, dim_in, boost_run, boost_switch;
  logic             s2_high, se;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [1:0][14:0] string_current;
  logic [1:0]       sink_on, headroom_minimum_selector, overvoltage_threshold;
  logic [1:0]       open_str, short_ovp, short_vin;
  logic [4:0]       duty;
  bbrc_sense_s      sense;
  int               err_total, n_checks, n;
  int               hp[4] = '{50, 25, 44, 22};
  bbrc_top #(.START_MIN_CYC_P(300), .SHUT_ZERO_CYC_P(300),
    .RAMP_BASE_CYC_P(256)) bbrc_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hardware_enable_pin, .dim_in, .sense,
    .string_current, .sink_on, .headroom_minimum_selector,
    .overvoltage_threshold, .boost_run, .boost_switch);
  bbrc_afe_model bbrc_afe_model_i (.pclk, .presetn, .boost_run, .duty,
    .open_str, .short_ovp, .short_vin, .s2_high, .dim_in, .sense);
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // waits for a sink current; on the way it may only move toward it
  task automatic wait_cur(input int i, input logic [14:0] e, input int lim);
    logic [14:0] p;
    p = string_current[i];
    n = 0;
    while (string_current[i] !== e && n < lim) begin
      @(negedge pclk);
      n++;
      if (e > p ? string_current[i] < p : string_current[i] > p)
        chk("ramp direction", 32'h0, 32'h1);
      p = string_current[i];
    end
    chk("sink current", 32'(string_current[i]), 32'(e));
    if (string_current[i] !== e) end_of_test();
  endtask
  // waits for the next switching edge, n holds the cycles waited
  task automatic edge_wait();
    logic s;
    s = boost_switch;
    n = 0;
    while (boost_switch === s && n < 200) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge pclk);
  endtask
  task automatic t_defaults();
    rdc("cfg", OFS_CFG, 32'h30);
    rdc("boost", OFS_BOOST, 32'h4);
    rdc("full scale b", OFS_FSB, 32'h1f);
    rdc("unmapped", 8'h3c, 32'h0);
    chk("slverr", 32'(se), 32'h1);
    chk("ovp level", 32'(overvoltage_threshold), 32'h1);
    $display("test defaults done");
  endtask
  task automatic t_ramps();
    wr(OFS_CFG, 32'h31);
    wr(OFS_BRA, 32'hff);
    wait_cur(0, 15'h6e5a, 400);
    chk("startup span", 32'(n inside {[300:304]}), 32'h1);
    chk("bank a shared", 32'(string_current[1]), 32'h6e5a);
    wr(OFS_CFG, 32'h33);
    wr(OFS_FSB, 32'h0);
    wr(OFS_BRB, 32'hff);
    wait_cur(1, 15'h1388, 400);
    chk("bank a kept", 32'(string_current[0]), 32'h6e5a);
    wr(OFS_BRA, 32'h33);
    wait_cur(0, 15'h1612, 5);
    wr(OFS_RUN, 32'h1);
    wr(OFS_BRA, 32'hff);
    wait_cur(0, 15'h6e5a, 400);
    chk("run ramp span", 32'(n inside {[256:260]}), 32'h1);
    $display("test ramps done");
  endtask
  task automatic t_freq();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BOOST, 32'(4 + i));
      edge_wait();
      edge_wait();
      edge_wait();
      chk("half period", 32'(n), 32'(hp[i]));
    end
    $display("test frequency done");
  endtask
  task automatic t_dim();
    wr(OFS_CFG, 32'h39);
    @(posedge pclk);
    duty <= 5'h0;
    settle();
    chk("dim off", 32'(sink_on[0]), 32'h0);
    wr(OFS_CFG, 32'h3d);
    settle();
    chk("dim active low", 32'(sink_on[0]), 32'h1);
    @(posedge pclk);
    duty <= 5'h10;
    $display("test dimming done");
  endtask
  task automatic t_head();
    wr(OFS_CFG, 32'h31);
    @(posedge pclk);
    s2_high <= 1'b1;
    settle();
    chk("headroom pick", 32'(headroom_minimum_selector), 32'h2);
    @(posedge pclk);
    s2_high <= 1'b0;
    settle();
    chk("headroom pick", 32'(headroom_minimum_selector), 32'h1);
    wr(OFS_CFG, 32'h21);
    settle();
    chk("single string", 32'(headroom_minimum_selector), 32'h2);
    $display("test headroom done");
  endtask
  task automatic t_fault();
    @(posedge pclk);
    open_str <= 2'b01;
    short_vin <= 2'b01;
    settle();
    rdc("flags", OFS_FAULT, 32'h10);
    wr(OFS_CFG, 32'h31);
    settle();
    rdc("flags", OFS_FAULT, 32'h14);
    open_str <= 2'b00;
    short_vin <= 2'b00;
    wr(OFS_FAULT, 32'h14);
    rdc("flags cleared", OFS_FAULT, 32'h0);
    wr(OFS_FAULT, 32'h1);
    open_str <= 2'b01;
    settle();
    open_str <= 2'b00;
    repeat (60) @(negedge pclk);
    chk("boost held off", 32'(boost_run), 32'h0);
    rdc("overvoltage_fault_flag", OFS_FAULT, 32'h7);
    wr(OFS_SWRST, 32'h1);
    rdc("fault reset", OFS_FAULT, 32'h0);
    rdc("bright reset", OFS_BRA, 32'h0);
    $display("test faults done");
  endtask
  task automatic t_pin();
    wr(OFS_BRA, 32'hff);
    wait_cur(0, 15'h6e5a, 400);
    wr(OFS_BRA, 32'h0);
    wait_cur(0, 15'h0, 400);
    chk("zero code span", 32'(n inside {[300:304]}), 32'h1);
    wr(OFS_BRA, 32'hff);
    wait_cur(0, 15'h6e5a, 400);
    @(posedge pclk);
    hardware_enable_pin <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("pin cut", 32'(string_current[0]), 32'h0);
    @(posedge pclk);
    hardware_enable_pin <= 1'b1;
    rdc("bright default", OFS_BRA, 32'h0);
    $display("test enable pin done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    {presetn, psel, penable, pwrite, s2_high} = 5'h0;
    {open_str, short_ovp, short_vin} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hardware_enable_pin = 1'b1;
    duty = 5'h10;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_ramps();
    t_freq();
    t_dim();
    t_head();
    t_fault();
    t_pin();
    end_of_test();
  end
endmodule
